// >>> rtl/dlsc_regs.sv
`timescale 1ns/1ns
// How it works
// - Link-ready bit sets once downstream link found and capabilities known.
// - Transmit-status bit high only while transmitter active and receiver locked.
// - Transmit-status waits for valid video and correct single or dual mode.
// - Port-mode field meaningful only while transmit-status reads one.
// - Port-mode: 00 dual, 01 port0, 10 port1, 11 both ports.
// - Clock-detect bit mirrors the input PLL's clock-detect indication.
// - No-clock bit set when no input clock above programmed low limit.
// - Frequency-stable bit set when the detector finds the clock stable.
// - In independent mode status shows the selected port only.
// - Cable-type bit: 0 twisted pair, 1 coaxial.
// - Cable-type bit loaded from strap pin after reset; software may rewrite.
// - Swap bit shows swap state; software writes only with auto-correct off.
// - With reset-on-change set, each frequency change on the selected port pulses the PLL reset.
// - Detector source: 0 raw input clock, 1 PLL output clock.
// - Swap-correction disable bit stops auto-correct and unlocks swap writes.
// - Stable only after staying in range 40us, 80us, 320us or 1.28ms.
module dlsc_regs
  import dlsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  output logic      [7:0] wb_dat_o,
  input  wire logic       wb_we_i,
  input  wire logic [0:0] wb_sel_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  output logic            wb_ack_o,
  input  wire dlsc_port_s port0_i,
  input  wire dlsc_port_s port1_i,
  input  wire logic       independent_mode,
  input  wire logic       auto_swap_state,
  input  wire logic       cable_strap_pin,
  output logic            cable_type_select,
  output logic            link_swap,
  output logic            freq_detector_source,
  output logic            serial_pll_reset,
  output logic      [7:0] low_frequency_limit,
  output logic            irq
);

  // ********************************
  // Bus decode
  // ********************************
  dlsc_req_s  req;
  wire logic  bus_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, we: wb_we_i, sel: wb_sel_i[0]};
  wire logic  wr_en      = bus_hit & req.we & req.sel;
  wire logic  wr_ctl1    = wr_en & (req.adr == IDX_CONTROL1);
  wire logic  wr_ctl2    = wr_en & (req.adr == IDX_CONTROL2);
  wire logic  wr_psel    = wr_en & (req.adr == IDX_PORT_SEL);
  wire logic  wr_ists    = wr_en & (req.adr == IDX_IRQ_STS);
  wire logic  wr_imsk    = wr_en & (req.adr == IDX_IRQ_MASK);
  wire logic  wr_flow    = wr_en & (req.adr == IDX_LOW_FREQUENCY_LIMIT);

  logic       cable_ff, swap_ff, pllrst_en_ff, src_ff;
  logic       swap_dis_ff, psel_ff, strap_done_ff;
  logic [1:0] thr_ff;
  logic [7:0] flow_ff, sts_ff, ists_ff, imsk_ff, rdat_ff;
  logic       ack_ff, irq_ff, pllrst_ff;
  logic [STBL_W-1:0] stbl_cnt_ff;
  logic       stable_ff;

  // ********************************
  // Selected port view
  // ********************************
  // selected port view
  wire dlsc_port_s sel_p = (independent_mode & psel_ff) ? port1_i : port0_i;

  // ********************************
  // Stability timer
  // ********************************
  logic [STBL_W-1:0] stbl_lim;
  assign stbl_lim = (thr_ff == 2'h0) ? STBL_W'(STBL_CYC_0) :
                    (thr_ff == 2'h1) ? STBL_W'(STBL_CYC_1) :
                    (thr_ff == 2'h2) ? STBL_W'(STBL_CYC_2) : STBL_W'(STBL_CYC_3);
  wire logic in_range  = sel_p.freq_in_range & sel_p.freq_above_low;
  wire logic stbl_hit  = (stbl_cnt_ff >= stbl_lim - STBL_W'(1));
  wire logic [STBL_W-1:0] nxt_stbl_cnt =
    !in_range ? '0 : (stbl_hit ? stbl_cnt_ff : stbl_cnt_ff + STBL_W'(1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stbl_cnt_ff <= '0;
      stable_ff   <= 1'b0;
    end else begin
      stbl_cnt_ff <= nxt_stbl_cnt;
      stable_ff   <= in_range & stbl_hit;
    end
  end

  // ********************************
  // Status word
  // ********************************
  logic [7:0] nxt_sts;
  logic       tx_lock;
  assign tx_lock = sel_p.tx_active & sel_p.rx_locked & sel_p.video_valid & sel_p.mode_ok;
  always_comb begin
    nxt_sts = RST_STATUS;
    nxt_sts[STS_LINK_RDY] = sel_p.link_ready;
    nxt_sts[STS_TX_LOCK]  = tx_lock;
    nxt_sts[STS_MODE_HI:STS_MODE_LO] = tx_lock ? sel_p.port_mode : MODE_DUAL;
    nxt_sts[STS_CLK_DET]  = sel_p.clk_detect;
    nxt_sts[STS_NO_CLK]   = ~sel_p.freq_above_low;
    nxt_sts[STS_FREQ_STBL] = stable_ff;
  end

  // ********************************
  // Interrupt status
  // ********************************
  // Events: link ready rise, lock rise, lock loss, stable rise
  logic [7:0] evt;
  assign evt = {4'h0, ~nxt_sts[STS_TX_LOCK] & sts_ff[STS_TX_LOCK],
                nxt_sts[STS_FREQ_STBL] & ~sts_ff[STS_FREQ_STBL],
                nxt_sts[STS_TX_LOCK] & ~sts_ff[STS_TX_LOCK],
                nxt_sts[STS_LINK_RDY] & ~sts_ff[STS_LINK_RDY]};
  // Set wins over write-one-to-clear
  wire logic [7:0] nxt_ists = evt | (ists_ff & ~(wr_ists ? req.dat : 8'h00));

  // ********************************
  // Control registers
  // ********************************
  // swap writable only when correction disabled
  wire logic nxt_swap = swap_dis_ff ? (wr_ctl1 ? req.dat[C1_SWAP] : swap_ff)
                                    : auto_swap_state;
  wire logic nxt_pllrst = pllrst_en_ff & sel_p.freq_change;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cable_ff      <= 1'b0;
      strap_done_ff <= 1'b0;
      swap_ff       <= 1'b0;
      pllrst_en_ff  <= 1'b0;
      src_ff        <= 1'b0;
      swap_dis_ff   <= 1'b0;
      thr_ff        <= RST_THR;
      psel_ff       <= 1'b0;
      flow_ff       <= RST_LOW_FREQUENCY_LIMIT;
      imsk_ff       <= 8'h00;
    end else begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff) begin
        cable_ff <= cable_strap_pin;
      end else if (wr_ctl1) begin
        cable_ff <= req.dat[C1_CABLE];
      end
      swap_ff <= nxt_swap;
      if (wr_ctl1) begin
        pllrst_en_ff <= req.dat[C1_PLL_RST];
        src_ff       <= req.dat[C1_FD_SRC];
      end
      if (wr_ctl2) begin
        swap_dis_ff <= req.dat[C2_SWAP_DIS];
        thr_ff      <= req.dat[C2_THR_HI:C2_THR_LO];
      end
      if (wr_psel) psel_ff <= req.dat[0];
      if (wr_imsk) imsk_ff <= req.dat;
      if (wr_flow) flow_ff <= req.dat;
    end
  end

  // ********************************
  // Read mux and ack
  // ********************************
  logic [7:0] rmux;
  always_comb begin
    unique case (req.adr)
      IDX_STATUS:   rmux = sts_ff;
      IDX_CONTROL1: rmux = {cable_ff, swap_ff, pllrst_en_ff, src_ff, 4'h0};
      IDX_CONTROL2: rmux = {swap_dis_ff, 2'h0, thr_ff, 3'h0};
      IDX_PORT_SEL: rmux = {7'h00, psel_ff};
      IDX_IRQ_STS:  rmux = ists_ff;
      IDX_IRQ_MASK: rmux = imsk_ff;
      IDX_LOW_FREQUENCY_LIMIT: rmux = flow_ff;
      default:      rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sts_ff    <= RST_STATUS;
      ists_ff   <= 8'h00;
      rdat_ff   <= 8'h00;
      ack_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      pllrst_ff <= 1'b0;
    end else begin
      sts_ff    <= nxt_sts;
      ists_ff   <= nxt_ists;
      ack_ff    <= bus_hit;
      if (bus_hit) rdat_ff <= rmux;
      // Level irq, one cycle behind status
      irq_ff    <= |(ists_ff & imsk_ff);
      pllrst_ff <= nxt_pllrst;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign wb_ack_o             = ack_ff;
  assign wb_dat_o             = rdat_ff;
  assign irq                  = irq_ff;
  assign serial_pll_reset     = pllrst_ff;
  assign cable_type_select    = cable_ff;
  assign link_swap            = swap_ff;
  assign freq_detector_source = src_ff;
  assign low_frequency_limit  = flow_ff;

endmodule : dlsc_regs

// >>> rtl/dlsc_pkg.sv
package dlsc_pkg;

  // ********************************
  // Register map (offsets are register indices; byte address = 4 * index)
  // ********************************
  localparam logic [7:0] IDX_STATUS   = 8'h5A;
  localparam logic [7:0] IDX_CONTROL1 = 8'h5B;
  localparam logic [7:0] IDX_CONTROL2 = 8'h5C;
  localparam logic [7:0] IDX_PORT_SEL = 8'h60;
  localparam logic [7:0] IDX_IRQ_STS  = 8'h61;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h62;
  localparam logic [7:0] IDX_LOW_FREQUENCY_LIMIT = 8'h63;

  // ********************************
  // Field positions
  // ********************************
  localparam int STS_LINK_RDY  = 7;
  localparam int STS_TX_LOCK   = 6;
  localparam int STS_MODE_HI   = 5;
  localparam int STS_MODE_LO   = 4;
  localparam int STS_CLK_DET   = 3;
  localparam int STS_NO_CLK    = 1;
  localparam int STS_FREQ_STBL = 0;
  localparam int C1_CABLE      = 7;
  localparam int C1_SWAP       = 6;
  localparam int C1_PLL_RST    = 5;
  localparam int C1_FD_SRC     = 4;
  localparam int C2_SWAP_DIS   = 7;
  localparam int C2_THR_HI     = 4;
  localparam int C2_THR_LO     = 3;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [7:0] RST_LOW_FREQUENCY_LIMIT = 8'h08;
  localparam logic [1:0] RST_THR      = 2'h0;

  // ********************************
  // Port modes
  // ********************************
  localparam logic [1:0] MODE_DUAL  = 2'h0;
  localparam logic [1:0] MODE_PORT0 = 2'h1;
  localparam logic [1:0] MODE_PORT1 = 2'h2;
  localparam logic [1:0] MODE_BOTH  = 2'h3;

  // ********************************
  // Stability timing at 100 MHz
  // ********************************
  localparam int CLK_MHZ        = 100;
  localparam int STBL_US_0      = 40;
  localparam int STBL_US_1      = 80;
  localparam int STBL_US_2      = 320;
  localparam int STBL_US_3      = 1280;
  localparam int STBL_CYC_0     = STBL_US_0 * CLK_MHZ;
  localparam int STBL_CYC_1     = STBL_US_1 * CLK_MHZ;
  localparam int STBL_CYC_2     = STBL_US_2 * CLK_MHZ;
  localparam int STBL_CYC_3     = STBL_US_3 * CLK_MHZ;
  localparam int STBL_W         = 18;

  // ********************************
  // Per-port status from the link and clock logic
  // ********************************
  typedef struct packed {
    logic       link_ready;
    logic       tx_active;
    logic       rx_locked;
    logic       video_valid;
    logic       mode_ok;
    logic [1:0] port_mode;
    logic       clk_detect;
    logic       freq_in_range;
    logic       freq_above_low;
    logic       freq_change;
  } dlsc_port_s;

  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] dat;
    logic       we;
    logic       sel;
  } dlsc_req_s;

endpackage : dlsc_pkg

// >>> dv/dlsc_properties.sv
`timescale 1ns/1ns
// ********************************
// Register port checks
// ********************************
module dlsc_properties
  import dlsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_we_i,
  input wire logic [0:0] wb_sel_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire dlsc_port_s port0_i,
  input wire dlsc_port_s port1_i,
  input wire logic       independent_mode,
  input wire logic       auto_swap_state,
  input wire logic       cable_strap_pin,
  input wire logic       cable_type_select,
  input wire logic       link_swap,
  input wire logic       freq_detector_source,
  input wire logic       serial_pll_reset,
  input wire logic [7:0] low_frequency_limit,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_sts = wb_ack_o & ~wb_we_i & (wb_adr_i == IDX_STATUS);
  wire mapped = wb_adr_i inside {[IDX_STATUS:IDX_CONTROL2], [IDX_PORT_SEL:IDX_LOW_FREQUENCY_LIMIT]};
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_mode_hide; rd_sts && !wb_dat_o[STS_TX_LOCK] |-> wb_dat_o[5:4] == 2'h0; endproperty
  a_mode_hide: assert property (p_mode_hide) else $error("mode shown unlocked");
  property p_rsvd; rd_sts |-> !wb_dat_o[2]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_unmap; wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_pll; serial_pll_reset |-> $past(port0_i.freq_change | port1_i.freq_change); endproperty
  a_pll: assert property (p_pll) else $error("pll reset without change");
  property p_src; $changed(freq_detector_source) |-> $past(wb_stb_i & wb_we_i); endproperty
  a_src: assert property (p_src) else $error("source changed alone");
  property p_lim; $changed(low_frequency_limit) |-> $past(wb_stb_i & wb_we_i); endproperty
  a_lim: assert property (p_lim) else $error("limit changed alone");
  property p_strap; !$past(rst_b, 2) && $past(rst_b) |-> cable_type_select == $past(cable_strap_pin);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");
  c_lock: cover property (rd_sts && wb_dat_o[STS_TX_LOCK]);
  c_pll: cover property (serial_pll_reset);
  c_irq: cover property (irq);
endmodule : dlsc_properties

bind dlsc_regs dlsc_properties i_chk (.*);

// >>> dv/dlsc_partner.sv
`timescale 1ns/1ns
// ********************************
// Link and clock logic stand-in
// ********************************
module dlsc_partner
  import dlsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire dlsc_port_s want0,
  input  wire dlsc_port_s want1,
  input  wire logic [3:0] lag,
  input  wire logic       swap_want,
  output dlsc_port_s      port0_o,
  output dlsc_port_s      port1_o,
  output logic            swap_o
);
  logic [3:0] cnt_ff;
  // Slow answers lag the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port0_o <= '0;
      port1_o <= '0;
      swap_o  <= 1'b0;
      cnt_ff  <= 4'h0;
    end else begin
      cnt_ff <= (want0 == port0_o && want1 == port1_o) ? 4'h0 : cnt_ff + 4'h1;
      if (cnt_ff >= lag) begin
        port0_o <= want0;
        port1_o <= want1;
      end
      swap_o <= swap_want;
    end
  end
endmodule : dlsc_partner

// >>> dv/dlsc_regs_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
// ********************************
// Bench
// ********************************
module dlsc_regs_tb
  import dlsc_pkg::*;
;
  typedef struct packed {dlsc_port_s p; logic [7:0] e;} dlsc_row_s;
  logic       clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic       indep = 1'b0, swap_want = 1'b0;
  logic [7:0] adr = 8'h00, dat = 8'h00, dat_o, flim, rd;
  logic [3:0] lag = 4'h0;
  logic       ack, cable, lswap, src, pllr, irq, swap_st, s;
  dlsc_port_s want0 = '0, want1 = '0, port0, port1;
  int         checked = 0, fail_count = 0;
  dlsc_row_s  rows [10] = '{'{11'h000, 8'h02}, '{11'h402, 8'h80}, '{11'h3C2, 8'h40},
    '{11'h3D2, 8'h50}, '{11'h3E2, 8'h60}, '{11'h3F2, 8'h70}, '{11'h372, 8'h00},
    '{11'h3B2, 8'h00}, '{11'h2F2, 8'h00}, '{11'h008, 8'h0A}};
  always #5 clk = ~clk;
  dlsc_partner i_far (.clk(clk), .rst_b(rst_b), .want0(want0), .want1(want1), .lag(lag),
    .swap_want(swap_want), .port0_o(port0), .port1_o(port1), .swap_o(swap_st));
  dlsc_regs i_dut (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .port0_i(port0), .port1_i(port1), .independent_mode(indep), .auto_swap_state(swap_st),
    .cable_strap_pin(1'b1), .cable_type_select(cable), .link_swap(lswap),
    .freq_detector_source(src), .serial_pll_reset(pllr), .low_frequency_limit(flim), .irq(irq));
  task automatic conclude();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb} <= 2'h0;
    if (n >= 20) begin
      fail_count++;
      conclude();
    end
  endtask : wb
  task automatic fc_pulse(output logic f);
    lag <= 4'h0;
    @(posedge clk);
    want0.freq_change <= 1'b1;
    @(posedge clk);
    want0.freq_change <= 1'b0;
    f = 1'b0;
    repeat (5) @(posedge clk) f = f | (pllr === 1'b1);
  endtask : fc_pulse
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      lag <= i[0] ? 4'h3 : 4'h0;
      want0 <= rows[i].p;
      repeat (8) @(posedge clk);
      wb(1'b0, IDX_STATUS, 8'h00, rd);
      `CHK(rd, rows[i].e)
    end
    $display("status table done");
    wb(1'b1, IDX_IRQ_MASK, 8'h00, rd);
    wb(1'b1, IDX_IRQ_STS, 8'hFF, rd);
    want0 <= 11'h3C2;
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b0)
    wb(1'b0, IDX_IRQ_STS, 8'h00, rd);
    `CHK(rd[1], 1'b1)
    wb(1'b1, IDX_IRQ_MASK, 8'h02, rd);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1'b1, IDX_IRQ_STS, 8'h02, rd);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    indep <= 1'b1;
    want1 <= 11'h3E2;
    wb(1'b1, IDX_PORT_SEL, 8'h01, rd);
    repeat (8) @(posedge clk);
    wb(1'b0, IDX_STATUS, 8'h00, rd);
    `CHK(rd, 8'h60)
    indep <= 1'b0;
    wb(1'b1, IDX_CONTROL1, 8'h30, rd);
    @(posedge clk);
    `CHK({cable, src}, 2'h1)
    fc_pulse(s);
    `CHK(s, 1'b1)
    wb(1'b1, IDX_CONTROL1, 8'h00, rd);
    fc_pulse(s);
    `CHK(s, 1'b0)
    $display("irq, port and control done");
    swap_want <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(lswap, 1'b1)
    wb(1'b1, IDX_CONTROL1, 8'h00, rd);
    @(posedge clk);
    `CHK(lswap, 1'b1)
    wb(1'b1, IDX_CONTROL2, 8'h80, rd);
    wb(1'b1, IDX_CONTROL1, 8'h00, rd);
    @(posedge clk);
    `CHK(lswap, 1'b0)
    wb(1'b1, 8'h10, 8'hFF, rd);
    wb(1'b0, 8'h10, 8'h00, rd);
    `CHK(rd, 8'h00)
    wb(1'b1, IDX_STATUS, 8'hFF, rd);
    wb(1'b0, IDX_STATUS, 8'h00, rd);
    `CHK(rd, 8'h40)
    wb(1'b1, IDX_LOW_FREQUENCY_LIMIT, 8'h33, rd);
    @(posedge clk);
    `CHK(flim, 8'h33)
    want0 <= 11'h006;
    repeat (3000) @(posedge clk);
    wb(1'b0, IDX_STATUS, 8'h00, rd);
    `CHK(rd[0], 1'b0)
    repeat (1200) @(posedge clk);
    wb(1'b0, IDX_STATUS, 8'h00, rd);
    `CHK(rd[0], 1'b1)
    $display("swap, map and stability done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({flim, lswap, src, irq}, 11'h040)
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wb(1'b0, IDX_CONTROL1, 8'h00, rd);
    `CHK(rd[7], 1'b1)
    $display("reset done");
    conclude();
  end
endmodule : dlsc_regs_tb
